// File: logic/dacr_pkg.sv
/*
  Package for the diagnostic and converter configuration register bank:
  offsets, field positions, reset values and the carrier structs.
  Assumes an 8-bit register access port fed by the serial frame logic.
*/
package dacr_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_CH = 4;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_ONSTATE_OPEN_LOAD_ENABLE = 8'h29;
  localparam logic [7:0] OFS_SUPPLY_SHORT_DIAG_ENABLE = 8'h2A;
  localparam logic [7:0] OFS_CURRENT_SENSE_CONV_DIS   = 8'h2B;
  localparam logic [7:0] OFS_TEMP_SENSE_CONV_DIS      = 8'h2C;
  localparam logic [7:0] OFS_VOLT_SENSE_CONV_DIS      = 8'h2D;
  localparam logic [7:0] OFS_CONVERTER_GLOBAL_CONFIG  = 8'h2E;
  localparam logic [7:0] OFS_FRAME_CHECK_CONFIG       = 8'h2F;

  // ----------------------------------------------------------------
  // Field positions and masks
  // ----------------------------------------------------------------
  localparam int unsigned CH1_BIT                = 0;
  localparam int unsigned CH4_BIT                = 3;
  localparam int unsigned GLB_SUPPLY_MEAS_DIS    = 0;
  localparam int unsigned GLB_CURRENT_DIS        = 1;
  localparam int unsigned GLB_VOLT_DIS           = 2;
  localparam int unsigned GLB_TEMP_DIS           = 3;
  localparam int unsigned FRM_CHECK_EN_BIT       = 0;
  localparam int unsigned FRM_LONG_FRAME_BIT     = 1;
  localparam logic [7:0]  CH_REG_MASK            = 8'h0F;
  localparam logic [7:0]  GLB_REG_MASK           = 8'h0F;
  localparam logic [7:0]  FRM_REG_MASK           = 8'h03;
  localparam logic [7:0]  REG_RESET              = 8'h00;
  localparam logic [7:0]  UNMAPPED_READ          = 8'h00;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        wr_en;
    logic        rd_en;
    logic [7:0]  addr;
    logic [7:0]  wdata;
  } dacr_req_s;

  typedef struct packed {
    logic        rd_valid;
    logic        hit;
    logic [7:0]  rdata;
  } dacr_rsp_s;

  typedef struct packed {
    logic [3:0]  onstate_open_load_en;
    logic [3:0]  supply_short_en;
  } dacr_diag_s;

  typedef struct packed {
    logic [3:0]  load_current_sense_conv;
    logic [3:0]  temperature_sense_conv;
    logic [3:0]  output_voltage_sense_conv;
    logic        supply_meas_conv;
  } dacr_conv_s;

  typedef struct packed {
    logic        long_frame_select;
    logic        frame_check_en;
  } dacr_frame_s;

endpackage

// File: logic/dacr_reg8.sv
/*
  One 8-bit configuration register with a writable-bit mask.
  Assumes a synchronous active-low reset and a one-cycle write strobe.
*/
module dacr_reg8 #(
  parameter logic [7:0] WR_MASK   = 8'hFF,
  parameter logic [7:0] RST_VALUE = 8'h00
) (
  input  wire logic       ref_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] value_o
);

  logic [7:0] value_q;
  logic [7:0] value_d;

  // Masked bits stay at reset value whatever is written
  assign value_d = wr_i ? (wdata_i & WR_MASK) : value_q;

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      value_q <= RST_VALUE & WR_MASK;
    end else begin
      value_q <= value_d;
    end
  end

  assign value_o = value_q;

endmodule

// File: logic/dacr_regs.sv
/*
  Register bank for per-channel diagnostic enables, converter sequence
  disables and the serial frame check configuration.
  Assumes the serial frame logic presents decoded single-cycle reads and
  writes on the request struct, synchronous to ref_clk_i.
*/

module dacr_regs #(
  parameter int unsigned NUM_CH = dacr_pkg::NUM_CH
) (
  input  wire logic                  ref_clk_i,
  input  wire logic                  reset_n_i,
  input  wire dacr_pkg::dacr_req_s   req_i,
  output dacr_pkg::dacr_rsp_s        rsp_o,
  output dacr_pkg::dacr_diag_s       diag_o,
  output dacr_pkg::dacr_conv_s       conv_o,
  output dacr_pkg::dacr_frame_s      frame_o
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  // Channel fields are fixed at four bits in the register layout
  if (NUM_CH != 4) begin : g_bad_ch
    $error("dacr_regs supports exactly four channels");
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic       sel_wbon;
  logic       sel_shrt;
  logic       sel_idis;
  logic       sel_tdis;
  logic       sel_vdis;
  logic       sel_glb;
  logic       sel_frm;
  logic       hit;
  logic [6:0] wr_sel;

  assign sel_wbon = req_i.addr == dacr_pkg::OFS_ONSTATE_OPEN_LOAD_ENABLE;
  assign sel_shrt = req_i.addr == dacr_pkg::OFS_SUPPLY_SHORT_DIAG_ENABLE;
  assign sel_idis = req_i.addr == dacr_pkg::OFS_CURRENT_SENSE_CONV_DIS;
  assign sel_tdis = req_i.addr == dacr_pkg::OFS_TEMP_SENSE_CONV_DIS;
  assign sel_vdis = req_i.addr == dacr_pkg::OFS_VOLT_SENSE_CONV_DIS;
  assign sel_glb  = req_i.addr == dacr_pkg::OFS_CONVERTER_GLOBAL_CONFIG;
  assign sel_frm  = req_i.addr == dacr_pkg::OFS_FRAME_CHECK_CONFIG;
  assign hit      = sel_wbon | sel_shrt | sel_idis | sel_tdis | sel_vdis | sel_glb | sel_frm;

  assign wr_sel = {7{req_i.wr_en}}
                & {sel_frm, sel_glb, sel_vdis, sel_tdis, sel_idis, sel_shrt, sel_wbon};

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] wbon_val;
  logic [7:0] shrt_val;
  logic [7:0] idis_val;
  logic [7:0] tdis_val;
  logic [7:0] vdis_val;
  logic [7:0] glb_val;
  logic [7:0] frm_val;

  // Upper nibble masked off so reserved bits never store
  dacr_reg8 #(
    .WR_MASK   (dacr_pkg::CH_REG_MASK),
    .RST_VALUE (dacr_pkg::REG_RESET)
  ) u_wbon (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .wr_i      (wr_sel[0]),
    .wdata_i   (req_i.wdata),
    .value_o   (wbon_val)
  );

  dacr_reg8 #(
    .WR_MASK   (dacr_pkg::CH_REG_MASK),
    .RST_VALUE (dacr_pkg::REG_RESET)
  ) u_shrt (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .wr_i      (wr_sel[1]),
    .wdata_i   (req_i.wdata),
    .value_o   (shrt_val)
  );

  dacr_reg8 #(
    .WR_MASK   (dacr_pkg::CH_REG_MASK),
    .RST_VALUE (dacr_pkg::REG_RESET)
  ) u_idis (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .wr_i      (wr_sel[2]),
    .wdata_i   (req_i.wdata),
    .value_o   (idis_val)
  );

  dacr_reg8 #(
    .WR_MASK   (dacr_pkg::CH_REG_MASK),
    .RST_VALUE (dacr_pkg::REG_RESET)
  ) u_tdis (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .wr_i      (wr_sel[3]),
    .wdata_i   (req_i.wdata),
    .value_o   (tdis_val)
  );

  dacr_reg8 #(
    .WR_MASK   (dacr_pkg::CH_REG_MASK),
    .RST_VALUE (dacr_pkg::REG_RESET)
  ) u_vdis (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .wr_i      (wr_sel[4]),
    .wdata_i   (req_i.wdata),
    .value_o   (vdis_val)
  );

  dacr_reg8 #(
    .WR_MASK   (dacr_pkg::GLB_REG_MASK),
    .RST_VALUE (dacr_pkg::REG_RESET)
  ) u_glb (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .wr_i      (wr_sel[5]),
    .wdata_i   (req_i.wdata),
    .value_o   (glb_val)
  );

  // Only the two frame bits store; 7..2 read zero
  dacr_reg8 #(
    .WR_MASK   (dacr_pkg::FRM_REG_MASK),
    .RST_VALUE (dacr_pkg::REG_RESET)
  ) u_frm (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .wr_i      (wr_sel[6]),
    .wdata_i   (req_i.wdata),
    .value_o   (frm_val)
  );

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [7:0]          rdata_mux;
  dacr_pkg::dacr_rsp_s rsp_q;
  dacr_pkg::dacr_rsp_s rsp_d;

  assign rdata_mux = sel_wbon ? wbon_val :
                     sel_shrt ? shrt_val :
                     sel_idis ? idis_val :
                     sel_tdis ? tdis_val :
                     sel_vdis ? vdis_val :
                     sel_glb  ? glb_val  :
                     sel_frm  ? frm_val  : dacr_pkg::UNMAPPED_READ;

  // Data held until the next read so the frame logic can sample late
  assign rsp_d.rd_valid = req_i.rd_en;
  assign rsp_d.hit      = req_i.rd_en ? hit : rsp_q.hit;
  assign rsp_d.rdata    = req_i.rd_en ? rdata_mux : rsp_q.rdata;

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  assign rsp_o = rsp_q;

  // ----------------------------------------------------------------
  // Diagnostic enables
  // ----------------------------------------------------------------
  // Channel n sits on bit n-1, channel 4 on bit 3
  assign diag_o.onstate_open_load_en = wbon_val[dacr_pkg::CH4_BIT:dacr_pkg::CH1_BIT];
  assign diag_o.supply_short_en      = shrt_val[dacr_pkg::CH4_BIT:dacr_pkg::CH1_BIT];

  // ----------------------------------------------------------------
  // Conversion enables
  // ----------------------------------------------------------------
  // Global disable overrides any per-channel enable
  assign conv_o.load_current_sense_conv =
    ~idis_val[dacr_pkg::CH4_BIT:dacr_pkg::CH1_BIT]
    & {4{~glb_val[dacr_pkg::GLB_CURRENT_DIS]}};
  assign conv_o.temperature_sense_conv =
    ~tdis_val[dacr_pkg::CH4_BIT:dacr_pkg::CH1_BIT]
    & {4{~glb_val[dacr_pkg::GLB_TEMP_DIS]}};
  assign conv_o.output_voltage_sense_conv =
    ~vdis_val[dacr_pkg::CH4_BIT:dacr_pkg::CH1_BIT]
    & {4{~glb_val[dacr_pkg::GLB_VOLT_DIS]}};
  assign conv_o.supply_meas_conv = ~glb_val[dacr_pkg::GLB_SUPPLY_MEAS_DIS];

  // ----------------------------------------------------------------
  // Frame configuration
  // ----------------------------------------------------------------
  // Frame logic must apply these from the next frame on, not mid-frame
  assign frame_o.long_frame_select = frm_val[dacr_pkg::FRM_LONG_FRAME_BIT];
  assign frame_o.frame_check_en    = frm_val[dacr_pkg::FRM_CHECK_EN_BIT];

endmodule

// File: bench/dacr_regs_monitor.sv
/*
  Checker for the register bank, watching the top module ports only.
  Assumes one clock and a synchronous active-low reset; bound below.
*/
module dacr_regs_chk (
  input wire logic                  ref_clk_i,
  input wire logic                  reset_n_i,
  input wire dacr_pkg::dacr_req_s   req_i,
  input wire dacr_pkg::dacr_rsp_s   rsp_o,
  input wire dacr_pkg::dacr_diag_s  diag_o,
  input wire dacr_pkg::dacr_conv_s  conv_o,
  input wire dacr_pkg::dacr_frame_s frame_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Properties
  // ----
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  wire logic       w = req_i.wr_en;
  wire logic [7:0] a = req_i.addr;
  wire logic [7:0] d = req_i.wdata;
  rd_answer_a:
    assert property (req_i.rd_en |=> rsp_o.rd_valid) else $error("read not answered");
  rd_quiet_a:
    assert property (!req_i.rd_en |=> !rsp_o.rd_valid) else $error("spurious read valid");
  ol_write_a:
    assert property (w && a == 8'h29 |=> diag_o.onstate_open_load_en == $past(d[3:0]))
    else $error("open-load enable wrong");
  short_write_a:
    assert property (w && a == 8'h2A |=> diag_o.supply_short_en == $past(d[3:0]))
    else $error("short enable wrong");
  cur_skip_a:
    assert property (w && a == 8'h2B |=> (conv_o.load_current_sense_conv & $past(d[3:0])) == 0)
    else $error("current conversion kept");
  tmp_skip_a:
    assert property (w && a == 8'h2C |=> (conv_o.temperature_sense_conv & $past(d[3:0])) == 0)
    else $error("temperature conversion kept");
  vlt_skip_a:
    assert property (w && a == 8'h2D |=> (conv_o.output_voltage_sense_conv & $past(d[3:0])) == 0)
    else $error("voltage conversion kept");
  glb_off_a:
    assert property (w && a == 8'h2E |=> ({|conv_o.temperature_sense_conv,
      |conv_o.output_voltage_sense_conv, |conv_o.load_current_sense_conv} & $past(d[3:1])) == 0)
    else $error("global disable ignored");
  supply_a:
    assert property (w && a == 8'h2E |=> conv_o.supply_meas_conv != $past(d[0]))
    else $error("supply measurement wrong");
  frame_cfg_a:
    assert property (w && a == 8'h2F |=> frame_o == $past(d[1:0])) else $error("frame config wrong");
  rsv_read_a:
    assert property (req_i.rd_en && a == 8'h2F |=> rsp_o.rdata[7:2] == 6'h00)
    else $error("reserved bits read nonzero");
  hold_cfg_a:
    assert property (!w |=> $stable(diag_o) && $stable(frame_o)) else $error("config moved");
  rst_val_a:
    assert property (disable iff (1'b0) !reset_n_i |=> diag_o == 0 && frame_o == 0 && rsp_o == 0
      && conv_o == '1)
    else $error("reset value wrong");
endmodule

bind dacr_regs dacr_regs_chk chk_u (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .req_i(req_i),
  .rsp_o(rsp_o), .diag_o(diag_o), .conv_o(conv_o), .frame_o(frame_o));

// File: bench/dacr_host.sv
/*
  Host model issuing single-cycle register accesses to the bank.
  Assumes requests launched at the falling edge, answer one edge later.
*/
module dacr_host (
  input  wire logic                ref_clk_i,
  input  wire dacr_pkg::dacr_rsp_s rsp_i,
  output dacr_pkg::dacr_req_s      req_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req_o = '0;
  // Idle bus shows the inverse, so stale values cannot pass for a request
  task automatic acc(input logic w, input logic r, input logic [7:0] a,
                     input logic [7:0] d, output logic [7:0] q, output logic ok);
    @(negedge ref_clk_i);
    req_o = {w, r, a, d};
    @(negedge ref_clk_i);
    req_o = {2'b00, ~a, ~d};
    ok = !r || rsp_i.rd_valid === 1'b1;
    q = rsp_i.rdata;
  endtask
endmodule

// File: bench/dacr_regs_tb.sv
/*
  Testbench: host model drives accesses, a behavioural copy of the
  registers predicts every read and every output.
  Assumes host and checker files are compiled before this one.
*/
module dacr_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("unexpected at %0t: got %h exp %h", $time, got, exp); end end
  // ----
  // Harness
  // ----
  logic                  ref_clk_i = 1'b0;
  logic                  reset_n_i = 1'b0;
  dacr_pkg::dacr_req_s   req;
  dacr_pkg::dacr_rsp_s   rsp;
  dacr_pkg::dacr_diag_s  diag;
  dacr_pkg::dacr_conv_s  conv;
  dacr_pkg::dacr_frame_s frame;
  int                    mismatches = 0;
  int                    num_checks = 0;
  logic [7:0]            m [7];
  logic [7:0]            q;
  logic [7:0]            held = 8'h00;
  logic                  ok;

  dacr_host host_u (.ref_clk_i(ref_clk_i), .rsp_i(rsp), .req_o(req));
  dacr_regs dut_u (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .req_i(req), .rsp_o(rsp),
    .diag_o(diag), .conv_o(conv), .frame_o(frame));

  initial forever #20 ref_clk_i = ~ref_clk_i;

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic outs();
    `CHK(diag, {m[0][3:0], m[1][3:0]})
    `CHK(conv.load_current_sense_conv, ~m[2][3:0] & ~{4{m[5][1]}})
    `CHK(conv.temperature_sense_conv, ~m[3][3:0] & ~{4{m[5][3]}})
    `CHK(conv.output_voltage_sense_conv, ~m[4][3:0] & ~{4{m[5][2]}})
    `CHK(conv.supply_meas_conv, ~m[5][0])
    `CHK(frame, m[6][1:0])
  endtask

  // Read with write in one cycle returns the old value
  task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    int i;
    i = int'(a) - 'h29;
    host_u.acc(w, r, a, d, q, ok);
    if (!ok) begin
      mismatches++;
      $display("unexpected at %0t: read not answered", $time);
      end_sim();
    end
    // Read data must stand until the next read
    if (r) held = (i >= 0 && i < 7) ? m[i] : 8'h00;
    if (r) `CHK(q, held)
    if (!r) `CHK(rsp.rdata, held)
    if (r) `CHK(rsp.hit, i >= 0 && i < 7)
    if (w && i >= 0 && i < 7) m[i] = d & ((i == 6) ? 8'h03 : 8'h0F);
    outs();
  endtask

  task automatic rst_read();
    reset_n_i = 1'b0;
    foreach (m[k]) m[k] = 8'h00;
    held = 8'h00;
    repeat (4) @(negedge ref_clk_i);
    `CHK(rsp.rdata, 8'h00)
    `CHK(rsp.hit, 1'b0)
    outs();
    reset_n_i = 1'b1;
    for (int k = 0; k < 9; k++) op(1'b0, 1'b1, 8'(8'h28 + k), 8'h00);
  endtask

  // ----
  // Sequence
  // ----
  initial begin
    void'($urandom(32'h7768_5bbb));
    rst_read();
    $display("test reset values done");
    for (int k = 0; k < 7; k++) begin
      for (int b = 0; b < 8; b++) op(1'b1, 1'b1, 8'(8'h29 + k), 8'(8'h01 << b));
    end
    $display("test walking bits done");
    repeat (300) op(1'($urandom), 1'($urandom), 8'(8'h27 + $urandom % 11), 8'($urandom));
    $display("test random access done");
    rst_read();
    $display("test mid-run reset done");
    end_sim();
  end
endmodule
